// [rtl/bpw_pkg.sv]
package bpw_pkg;
  // Instance bases in the controller's internal address space
  localparam logic [31:0] BPW_BASE0 = 32'h0000_b800;
  localparam logic [31:0] BPW_BASE1 = 32'h0000_b900;
  localparam logic [31:0] BPW_BASE2 = 32'h0000_ba00;
  localparam logic [7:0] BPW_OFF_CFG = 8'h00;
  localparam logic [7:0] BPW_OFF_LIM = 8'h04;
  localparam logic [7:0] BPW_OFF_DLY = 8'h08;
  localparam logic [7:0] BPW_OFF_STEP = 8'h0c;
  localparam logic [7:0] BPW_OFF_INT = 8'h10;
  // Configuration fields
  localparam int BPW_CFG_SYM_BIT = 16;
  localparam int BPW_CFG_SRST_BIT = 7;
  localparam int BPW_CFG_COMMIT_BIT = 6;
  localparam int BPW_CFG_SIZE_LSB = 4;
  localparam int BPW_CFG_SYNC_BIT = 3;
  localparam int BPW_CFG_CTRL_LSB = 0;
  localparam logic [31:0] BPW_CFG_RST = 32'h0000_1400;
  localparam logic [31:0] BPW_CFG_MASK = 32'h0001_ff7b;
  localparam logic [1:0] BPW_SIZE_8 = 2'h0;
  localparam logic [1:0] BPW_SIZE_7 = 2'h1;
  localparam logic [1:0] BPW_SIZE_6 = 2'h2;
  localparam logic [7:0] BPW_MAX_8 = 8'hff;
  localparam logic [7:0] BPW_MAX_7 = 8'hfe;
  localparam logic [7:0] BPW_MAX_6 = 8'hfc;
  localparam logic [1:0] BPW_CTRL_OFF = 2'h0;
  localparam logic [1:0] BPW_CTRL_ON = 2'h3;
  // Limits, delay and step/interval segment fields
  localparam int BPW_LIM_MIN_LSB = 0;
  localparam int BPW_LIM_MAX_LSB = 8;
  localparam int BPW_DLY_BOT_LSB = 0;
  localparam int BPW_DLY_TOP_LSB = 12;
  localparam int BPW_HOLD_W = 12;
  localparam int BPW_SEG_W = 4;
  localparam logic [31:0] BPW_REG_RST = 32'h0000_0000;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } bpw_bus_req_t;
endpackage

// [rtl/bpw_pwm_regs.sv]
`timescale 1ns/1ps
module bpw_pwm_regs #(
  parameter logic [31:0] BASE_ADDR = bpw_pkg::BPW_BASE0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input bpw_pkg::bpw_bus_req_t req,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic led_out,
  output logic period_end,
  output logic [11:0] top_hold_count,
  output logic [11:0] bottom_hold_count,
  output logic [3:0] seg_step,
  output logic [3:0] seg_interval
);
  import bpw_pkg::*;

  logic [31:0] cfg, hold_lim, op_lim, hold_dly, op_dly;
  logic [31:0] hold_step, op_step, hold_int, op_int;
  logic [7:0] pwm_cnt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address decode against the instance base
  wire hit = req.sel && (req.addr[31:8] == BASE_ADDR[31:8]);
  wire [7:0] off = req.addr[7:0];
  wire wr_any = hit && req.wr;
  wire rd_any = hit && !req.wr;
  wire wr_cfg = wr_any && (off == BPW_OFF_CFG);
  wire wr_lim = wr_any && (off == BPW_OFF_LIM);
  wire wr_dly = wr_any && (off == BPW_OFF_DLY);
  wire wr_step = wr_any && (off == BPW_OFF_STEP);
  wire wr_int = wr_any && (off == BPW_OFF_INT);

  wire [1:0] size = cfg[BPW_CFG_SIZE_LSB +: 2];
  wire [1:0] ctrl = cfg[BPW_CFG_CTRL_LSB +: 2];
  wire commit = cfg[BPW_CFG_COMMIT_BIT];
  wire sync = cfg[BPW_CFG_SYNC_BIT];
  wire symmetric = !cfg[BPW_CFG_SYM_BIT];

  // Reserved size code runs as 8-bit rather than locking up
  wire [7:0] cnt_max = (size == BPW_SIZE_7) ? BPW_MAX_7 :
                       (size == BPW_SIZE_6) ? BPW_MAX_6 :
                       BPW_MAX_8;
  // Using >= recovers at once when the size shrinks mid-period
  wire wrap = !sync && (pwm_cnt >= cnt_max);
  wire [7:0] next_cnt = (sync || wrap) ? 8'h00 : pwm_cnt + 8'h01;
  wire do_copy = wrap && commit;

  // Self-clearing soft reset bit is never stored
  wire soft_rst = wr_cfg && req.be[0] && req.wdata[BPW_CFG_SRST_BIT];
  wire commit_set = wr_cfg && req.be[0] && req.wdata[BPW_CFG_COMMIT_BIT];
  wire [31:0] cfg_wr = merge(cfg, req.wdata, req.be) & BPW_CFG_MASK;
  wire [31:0] cfg_base = wr_cfg ? cfg_wr : cfg;
  // A set in the same cycle as the hardware clear wins
  wire next_commit = commit_set || (commit && !do_copy);
  wire [31:0] next_cfg = {cfg_base[31:BPW_CFG_COMMIT_BIT+1], next_commit,
                          cfg_base[BPW_CFG_COMMIT_BIT-1:0]};

  wire [31:0] next_hold_lim = wr_lim ? merge(hold_lim, req.wdata, req.be)
                                     : hold_lim;
  wire [31:0] next_hold_dly = wr_dly ? merge(hold_dly, req.wdata, req.be)
                                     : hold_dly;
  wire [31:0] next_hold_step = wr_step ? merge(hold_step, req.wdata, req.be)
                                       : hold_step;
  wire [31:0] next_hold_int = wr_int ? merge(hold_int, req.wdata, req.be)
                                     : hold_int;

  // Reads return the holding copies; the configuration read shows the live commit bit, which firmware writes other than a soft reset cannot clear
  wire [31:0] next_rd = !rd_any ? 32'h0000_0000 :
                        (off == BPW_OFF_CFG) ? cfg :
                        (off == BPW_OFF_LIM) ? hold_lim :
                        (off == BPW_OFF_DLY) ? hold_dly :
                        (off == BPW_OFF_STEP) ? hold_step :
                        (off == BPW_OFF_INT) ? hold_int : 32'h0000_0000;

  // Duty source is the low bound; the breathing ramp engine sits elsewhere
  wire [7:0] duty = op_lim[BPW_LIM_MIN_LSB +: 8];
  wire [2:0] seg_idx = symmetric ? duty[7:5]
                                 : {1'b0, duty[7:6]};
  wire next_led = (ctrl == BPW_CTRL_ON) ||
                  ((ctrl != BPW_CTRL_OFF) && (pwm_cnt < duty));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= BPW_CFG_RST;
      hold_lim <= BPW_REG_RST;
      op_lim <= BPW_REG_RST;
      hold_dly <= BPW_REG_RST;
      op_dly <= BPW_REG_RST;
      hold_step <= BPW_REG_RST;
      op_step <= BPW_REG_RST;
      hold_int <= BPW_REG_RST;
      op_int <= BPW_REG_RST;
      pwm_cnt <= 8'h00;
    end else if (clk_en) begin
      if (soft_rst) begin
        cfg <= BPW_CFG_RST;
        hold_lim <= BPW_REG_RST;
        op_lim <= BPW_REG_RST;
        hold_dly <= BPW_REG_RST;
        op_dly <= BPW_REG_RST;
        hold_step <= BPW_REG_RST;
        op_step <= BPW_REG_RST;
        hold_int <= BPW_REG_RST;
        op_int <= BPW_REG_RST;
        pwm_cnt <= 8'h00;
      end else begin
        cfg <= next_cfg;
        hold_lim <= next_hold_lim;
        hold_dly <= next_hold_dly;
        hold_step <= next_hold_step;
        hold_int <= next_hold_int;
        pwm_cnt <= next_cnt;
        if (wrap) begin
          op_lim <= hold_lim;
        end
        if (do_copy) begin
          op_dly <= hold_dly;
          op_step <= hold_step;
          op_int <= hold_int;
        end
      end
    end
  end

  // Every output is a flop so the pins never see decode glitches
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 32'h0000_0000;
      rd_valid <= 1'b0;
      led_out <= 1'b0;
      period_end <= 1'b0;
      top_hold_count <= 12'h000;
      bottom_hold_count <= 12'h000;
      seg_step <= 4'h0;
      seg_interval <= 4'h0;
    end else if (clk_en) begin
      rd_data <= next_rd;
      rd_valid <= rd_any;
      led_out <= next_led;
      period_end <= wrap && !soft_rst;
      top_hold_count <= op_dly[BPW_DLY_TOP_LSB +: BPW_HOLD_W];
      bottom_hold_count <= op_dly[BPW_DLY_BOT_LSB +: BPW_HOLD_W];
      seg_step <= op_step[seg_idx*BPW_SEG_W +: BPW_SEG_W];
      seg_interval <= op_int[seg_idx*BPW_SEG_W +: BPW_SEG_W];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  wire quiet = clk_en && !soft_rst;

  // A configuration write may shrink the maximum under a running count
  a_cnt_bound: assert property (quiet && !wr_cfg |=>
    pwm_cnt <= cnt_max)
    else $error("period counter passed its maximum");
  a_wrap_zero: assert property (quiet && wrap |=> pwm_cnt == 8'h00
    && period_end)
    else $error("counter did not wrap to zero with period end");
  a_cfg_now: assert property (quiet && wr_cfg && req.be == 4'hf
    |=> cfg[5:4] == $past(req.wdata[5:4]))
    else $error("configuration write not applied at once");
  a_lim_xfer: assert property (quiet && wrap |=>
    op_lim == $past(hold_lim))
    else $error("limits not transferred at period end");
  a_lim_hold: assert property (quiet && !wrap |=>
    op_lim == $past(op_lim))
    else $error("limits changed outside a period end");
  a_no_commit: assert property (quiet && !commit |=>
    op_dly == $past(op_dly) && op_step == $past(op_step)
    && op_int == $past(op_int))
    else $error("breathing registers moved without commit");
  a_commit_copy: assert property (quiet && wrap && commit && !commit_set
    |=> !commit && op_dly == $past(hold_dly))
    else $error("commit copy or hardware clear missing");
  a_commit_sticky: assert property (quiet && commit && !wrap |=>
    commit)
    else $error("commit bit lost without a copy");
  a_byte_lane: assert property (quiet && wr_lim && req.be == 4'h1
    |=> hold_lim[31:8] == $past(hold_lim[31:8])
    && hold_lim[7:0] == $past(req.wdata[7:0]))
    else $error("partial write disturbed other bytes");
  a_unmapped: assert property (clk_en && hit && !req.wr &&
    off > BPW_OFF_INT |=> rd_data == 32'h0000_0000 && rd_valid)
    else $error("unmapped read did not return zero");
  a_rd_pulse: assert property (clk_en && !rd_any |=> !rd_valid)
    else $error("read valid without a decoded read");
  a_sync_hold: assert property (clk_en && sync |=>
    pwm_cnt == 8'h00 && !period_end)
    else $error("counter ran or period ended while held");
endmodule // bpw_pwm_regs

// [test/bpw_led_model.sv]
`timescale 1ns/1ps
// Counts lit cycles over each period, like an eye integrating brightness
module bpw_led_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic led_out,
  input wire logic period_end,
  output logic [8:0] lit
);
  logic [8:0] acc;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc <= 9'h000;
      lit <= 9'h000;
    end else if (period_end) begin
      lit <= acc + {8'h00, led_out};
      acc <= 9'h000;
    end else begin
      acc <= acc + {8'h00, led_out};
    end
  end
endmodule // bpw_led_model

// [test/bpw_pwm_regs_bench.sv]
`timescale 1ns/1ps
module bpw_pwm_regs_bench;
  import bpw_pkg::*;
  localparam logic [31:0] B = BPW_BASE1;
  logic clock, rst_b, clk_en, rd_valid, led_out, period_end;
  bpw_bus_req_t req;
  logic [31:0] rd_data;
  logic [11:0] top_h, bot_h;
  logic [3:0] s_step, s_int;
  logic [8:0] lit;
  int err_count, num_checks, n;
  int plen[3] = '{256, 255, 253};
  bpw_pwm_regs #(.BASE_ADDR(B)) bpw_pwm_regs_i (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .led_out(led_out), .period_end(period_end), .top_hold_count(top_h),
    .bottom_hold_count(bot_h), .seg_step(s_step), .seg_interval(s_int));
  bpw_led_model bpw_led_model_i (.clock(clock), .rst_b(rst_b),
    .led_out(led_out), .period_end(period_end), .lit(lit));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One access, then one idle cycle so sel never toggles twice in a step
  task automatic acc(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clock);
    req <= '{1'b1, w, a, d, be};
    @(posedge clock);
    req.sel <= 1'b0;
    #1;
  endtask
  task automatic wr(logic [7:0] o, logic [31:0] d, logic [3:0] be);
    acc(1'b1, B + {24'h0, o}, d, be);
  endtask
  task automatic rd(logic [31:0] a, logic v, logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'h0);
    chk("rd_valid", {31'h0, v}, {31'h0, rd_valid});
    chk("rd_data", e, rd_data);
  endtask
  task automatic wpe();
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (period_end !== 1'b1 && n < 600);
    if (n >= 600) begin
      err_count++;
      results();
    end
  endtask
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    req = '0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(B, 1'b1, BPW_CFG_RST);
    rd(B + 32'h14, 1'b1, 32'h0);
    rd(BPW_BASE0, 1'b0, 32'h0);
    wr(BPW_OFF_CFG, 32'h0000_1401, 4'hf);
    for (int s = 0; s < 3; s++) begin
      wr(BPW_OFF_CFG, 32'h0000_1401 | (s << 4), 4'h1);
      wpe();
      wpe();
      chk("period", plen[s], n);
    end
    wr(BPW_OFF_CFG, 32'h0000_1401, 4'h1);
    wpe();
    wr(BPW_OFF_LIM, 32'hffff_ff40, 4'h1);
    rd(B + 32'h4, 1'b1, 32'h0000_0040);
    wpe();
    chk("lit_old", 9'h000, lit);
    wpe();
    wpe();
    chk("lit_new", 9'h040, lit);
    // Firmware order: holding copies first, commit last
    wr(BPW_OFF_DLY, 32'h00ab_c123, 4'hf);
    wr(BPW_OFF_DLY, 32'h0000_00ff, 4'h1);
    wr(BPW_OFF_STEP, 32'h0000_3210, 4'h3);
    wr(BPW_OFF_STEP, 32'h7654_0000, 4'hc);
    wr(BPW_OFF_INT, 32'hfedc_ba98, 4'hf);
    rd(B + 32'h8, 1'b1, 32'h00ab_c1ff);
    rd(B + 32'hc, 1'b1, 32'h7654_3210);
    wpe();
    repeat (2) @(posedge clock);
    #1;
    chk("top_idle", 12'h000, top_h);
    rd(B + 32'h8, 1'b1, 32'h00ab_c1ff);
    wr(BPW_OFF_CFG, 32'h0000_1441, 4'hf);
    wr(BPW_OFF_CFG, 32'h0000_1401, 4'hf);
    rd(B, 1'b1, 32'h0000_1441);
    wpe();
    repeat (2) @(posedge clock);
    #1;
    chk("top_hold", 12'habc, top_h);
    chk("bot_hold", 12'h1ff, bot_h);
    chk("seg_step", 4'h2, s_step);
    chk("seg_int", 4'ha, s_int);
    rd(B, 1'b1, 32'h0000_1401);
    wr(BPW_OFF_CFG, 32'h0001_0000, 4'h4);
    repeat (2) @(posedge clock);
    #1;
    chk("asym_step", 4'h1, s_step);
    chk("asym_int", 4'h9, s_int);
    // Always-on lights every cycle of a full period
    wr(BPW_OFF_CFG, 32'h0000_1403, 4'h1);
    repeat (3) wpe();
    chk("lit_on", plen[0], lit);
    // Held counter must not end any period
    wr(BPW_OFF_CFG, 32'h0000_1409, 4'h1);
    n = 0;
    repeat (300) begin
      @(posedge clock);
      #1;
      if (period_end !== 1'b0) n++;
    end
    chk("sync_ends", 0, n);
    wr(BPW_OFF_CFG, 32'h0000_1401, 4'h1);
    wpe();
    chk("period_sync", plen[0], n);
    wpe();
    @(posedge clock);
    clk_en <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    wpe();
    // Ten frozen edges stretch the period; eleven passed before counting
    chk("period_frz", plen[0] + 10 - 11, n);
    wr(BPW_OFF_CFG, 32'h0000_0080, 4'h1);
    rd(B, 1'b1, BPW_CFG_RST);
    rd(B + 32'h4, 1'b1, 32'h0);
    results();
  end
endmodule // bpw_pwm_regs_bench
